/* inc/pmba_params.svh */
`ifndef PMBA_PARAMS_SVH
`define PMBA_PARAMS_SVH

// Register offsets on the configuration bus (byte addresses).
`define PMBA_CTRL_OFS 8'h00
`define PMBA_STAT_OFS 8'h04
`define PMBA_CNT_OFS 8'h08

// Control register fields and reset value.
`define PMBA_CTRL_PROG_BIT 0
`define PMBA_CTRL_HIGH_BIT 1
`define PMBA_CTRL_RST 2'h1

// Status register field positions.
`define PMBA_STAT_HIT_BIT 0
`define PMBA_STAT_WORD_BIT 1
`define PMBA_STAT_SHIFT_BIT 2
`define PMBA_STAT_INH_BIT 3
`define PMBA_STAT_STATE_LSB 4

// Array geometry: two arrays of 16K bytes each.
`define PMBA_ARR_AW 14

// Edges from a taken request to the answer on the system bus.
`define PMBA_ANSWER_LAT 3

`endif

/* inc/pmba_pkg.sv */
package pmba_pkg;

    // Access sequencer, Gray coded along IDLE, ACCESS, DELIVER, HOLD.
    typedef enum logic [1:0] {
        PMBA_IDLE = 2'b00,
        PMBA_ACCESS = 2'b01,
        PMBA_DELIVER = 2'b11,
        PMBA_HOLD = 2'b10
    } pmba_state_e;

    // Snapshot of the last request seen on the system bus.
    typedef struct packed {
        logic inhibited;
        logic shifted;
        logic word;
        logic hit;
    } pmba_stat_s;

endpackage

/* inc/pmba_arr_if.sv */
`timescale 1ns/100ps
interface pmba_arr_if #(
    parameter int AW = 14
);
    logic [AW-1:0] addr;
    logic we;
    logic low_en;
    logic high_en;
    logic [7:0] wdata_lo;
    logic [7:0] wdata_hi;
    logic [7:0] rdata_lo;
    logic [7:0] rdata_hi;

    // The sequencer drives the request, the arrays return read data.
    modport ctrl (
        output addr, we, low_en, high_en, wdata_lo, wdata_hi,
        input rdata_lo, rdata_hi
    );
    modport mem (
        input addr, we, low_en, high_en, wdata_lo, wdata_hi,
        output rdata_lo, rdata_hi
    );
endinterface

/* hw/pmba_addr_buf.sv */
`timescale 1ns/100ps
module pmba_addr_buf (
    input wire logic [15:0] sys_addr_n_i,
    input wire logic shift_i,
    output logic [14:0] buffered_address_o,
    output logic lowest_bus_bit_o
);
    logic [15:0] addr_pos;

    // The bus lines are active low; the buffers present them inverted.
    assign addr_pos = ~sys_addr_n_i;

    // Shifted routing keeps bit positions and grounds the lowest bus bit.
    always_comb begin
        if (shift_i) begin
            buffered_address_o = addr_pos[14:0];
            lowest_bus_bit_o = 1'b0;
        end else begin
            buffered_address_o = addr_pos[15:1];
            lowest_bus_bit_o = addr_pos[0];
        end
    end
endmodule

/* hw/pmba_array.sv */
`timescale 1ns/100ps
module pmba_array #(
    parameter int AW = 14
) (
    input wire logic clk_i,
    pmba_arr_if.mem arr
);
    localparam int DEPTH = 1 << AW;

    // Two byte-wide arrays; each only acts when its own lane enable is up.
    logic [7:0] low_mem [0:DEPTH-1];
    logic [7:0] high_mem [0:DEPTH-1];

    // Low array: synchronous write, registered read.
    always_ff @(posedge clk_i) begin
        if (arr.low_en) begin
            if (arr.we) begin
                low_mem[arr.addr] <= arr.wdata_lo;
            end
            arr.rdata_lo <= low_mem[arr.addr];
        end
    end

    // High array: same timing, so word accesses stay aligned.
    always_ff @(posedge clk_i) begin
        if (arr.high_en) begin
            if (arr.we) begin
                high_mem[arr.addr] <= arr.wdata_hi;
            end
            arr.rdata_hi <= high_mem[arr.addr];
        end
    end
endmodule

/* hw/pmba_board.sv */
// How it works
// - Active-low bus address is inverted into active-high buffered address lines.
// - Shifted routing when word access is low and narrow access is high.
// - Unshifted: line n feeds buffered n-1; shifted: n feeds n, low bit grounded.
// - Program board answers with space select high, system board with it low.
// - Byte mode chains both arrays to 32K bytes; word mode pairs them.
// - Word or byte operation decided from both controls and lowest bus bit.
// - Byte data rides the upper lanes when word access high, exchange low.
// - Asserted inhibit disables read and write buffers of both arrays.
// - Byte even hits low array, odd hits high array; word hits both.
// - Board position picks lower or upper 32K half of the address space.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "pmba_params.svh"
module pmba_board
    import pmba_pkg::*;
#(
    parameter int AW = `PMBA_ARR_AW
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] sys_addr_n_i,
    input wire logic word_access_n_i,
    input wire logic narrow_access_n_i,
    input wire logic memory_space_select_i,
    input wire logic array_inhibit_n_i,
    input wire logic lane_exchange_n_i,
    input wire logic sys_req_i,
    input wire logic sys_we_i,
    input wire logic [15:0] sys_data_i,
    output logic [15:0] sys_data_o,
    output logic [1:0] sys_data_oe_n_o,
    output logic sys_ack_o,
    output logic [14:0] buffered_address_o
);
    pmba_arr_if #(.AW(AW)) arr ();

    pmba_state_e state_q;
    logic [1:0] ctrl_q;
    pmba_stat_s stat_q;
    logic [15:0] xfer_cnt_q;
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic [14:0] ma_q;
    logic [15:0] sys_data_q;
    logic [1:0] oe_n_q;
    logic sys_ack_q;
    logic [AW-1:0] addr_q;
    logic we_q, lo_q, hi_q, word_q, upper_q, hit_q, xfer_q;
    logic [7:0] wd_lo_q, wd_hi_q;

    logic shift, byte_mode, word_mode, lo_sel, hi_sel, upper_lane;
    logic space_ok, board_ok, hit, xfer, take;
    logic [14:0] ma;
    logic lbb;
    logic [7:0] wd_byte, rd_byte;
    logic wb_take;

    // Shifted routing is only for word emulators that ask for it.
    assign shift = !word_access_n_i && narrow_access_n_i;

    pmba_addr_buf u_addr_buf (
        .sys_addr_n_i(sys_addr_n_i),
        .shift_i(shift),
        .buffered_address_o(ma),
        .lowest_bus_bit_o(lbb)
    );

    // Mode decode; both controls high is no legal mode and selects nothing.
    assign word_mode = !word_access_n_i;
    assign byte_mode = word_access_n_i && !narrow_access_n_i;
    assign lo_sel = word_mode || (byte_mode && !lbb);
    assign hi_sel = word_mode || (byte_mode && lbb);
    assign upper_lane = word_access_n_i && !lane_exchange_n_i;

    // Board qualification by memory space and by board position.
    assign space_ok = ctrl_q[`PMBA_CTRL_PROG_BIT] ? memory_space_select_i
                                                  : !memory_space_select_i;
    assign board_ok = ctrl_q[`PMBA_CTRL_HIGH_BIT] ? ma[14] : !ma[14];
    assign hit = space_ok && board_ok && (lo_sel || hi_sel);
    assign xfer = hit && array_inhibit_n_i;
    assign take = (state_q == PMBA_IDLE) && sys_req_i;

    // Byte writes take their data from whichever lane carries it.
    assign wd_byte = upper_lane ? sys_data_i[15:8] : sys_data_i[7:0];

    // Buffered address is registered every cycle for the relocation unit.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ma_q <= 15'h0000;
        end else begin
            ma_q <= ma;
        end
    end

    // Access sequencer; one access per request, released when req drops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= PMBA_IDLE;
        end else begin
            case (state_q)
                PMBA_IDLE: begin
                    if (sys_req_i) begin
                        state_q <= PMBA_ACCESS;
                    end
                end
                PMBA_ACCESS: state_q <= PMBA_DELIVER;
                PMBA_DELIVER: state_q <= PMBA_HOLD;
                PMBA_HOLD: begin
                    if (!sys_req_i) begin
                        state_q <= PMBA_IDLE;
                    end
                end
                default: state_q <= PMBA_IDLE;
            endcase
        end
    end

    // Request capture; holding it keeps the array stable while the bus moves.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= '0;
            we_q <= 1'b0;
            lo_q <= 1'b0;
            hi_q <= 1'b0;
            word_q <= 1'b0;
            upper_q <= 1'b0;
            hit_q <= 1'b0;
            xfer_q <= 1'b0;
            wd_lo_q <= 8'h00;
            wd_hi_q <= 8'h00;
        end else if (take) begin
            addr_q <= ma[AW-1:0];
            we_q <= sys_we_i;
            lo_q <= lo_sel;
            hi_q <= hi_sel;
            word_q <= word_mode;
            upper_q <= upper_lane;
            hit_q <= hit;
            xfer_q <= xfer;
            wd_lo_q <= word_mode ? sys_data_i[7:0] : wd_byte;
            wd_hi_q <= word_mode ? sys_data_i[15:8] : wd_byte;
        end
    end

    // Arrays act only in ACCESS and only for a qualified, uninhibited request.
    assign arr.addr = addr_q;
    assign arr.we = we_q;
    assign arr.low_en = (state_q == PMBA_ACCESS) && xfer_q && lo_q;
    assign arr.high_en = (state_q == PMBA_ACCESS) && xfer_q && hi_q;
    assign arr.wdata_lo = wd_lo_q;
    assign arr.wdata_hi = wd_hi_q;

    pmba_array #(.AW(AW)) u_array (
        .clk_i(clk_i),
        .arr(arr)
    );

    // In byte mode the odd array answers for odd addresses.
    assign rd_byte = lo_q ? arr.rdata_lo : arr.rdata_hi;

    // Bus answer; the data buffers open only for reads that really transfer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_data_q <= 16'h0000;
            oe_n_q <= 2'h3;
            sys_ack_q <= 1'b0;
        end else if (state_q == PMBA_DELIVER) begin
            sys_ack_q <= hit_q;
            if (word_q) begin
                sys_data_q <= {arr.rdata_hi, arr.rdata_lo};
                oe_n_q <= (xfer_q && !we_q) ? 2'h0 : 2'h3;
            end else if (upper_q) begin
                sys_data_q <= {rd_byte, 8'h00};
                oe_n_q <= (xfer_q && !we_q) ? 2'h1 : 2'h3;
            end else begin
                sys_data_q <= {8'h00, rd_byte};
                oe_n_q <= (xfer_q && !we_q) ? 2'h2 : 2'h3;
            end
        end else if (state_q == PMBA_HOLD && !sys_req_i) begin
            sys_data_q <= 16'h0000;
            oe_n_q <= 2'h3;
            sys_ack_q <= 1'b0;
        end
    end

    // Status snapshot of the latest request, for diagnostics.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else if (take) begin
            stat_q.hit <= hit;
            stat_q.word <= word_mode;
            stat_q.shifted <= shift;
            stat_q.inhibited <= !array_inhibit_n_i;
        end
    end

    // Completed array transfers; wraps silently, software takes differences.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_cnt_q <= 16'h0000;
        end else if (arr.low_en || arr.high_en) begin
            xfer_cnt_q <= xfer_cnt_q + 16'h0001;
        end
    end

    // Wishbone slave: ack one cycle after the strobe, unmapped reads as zero.
    assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
        end else begin
            wb_ack_q <= wb_take;
        end
    end

    // Only the control register is writable; lane 0 carries its bits.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PMBA_CTRL_RST;
        end else if (wb_take && wb_we_i && wb_sel_i[0] && wb_adr_i == `PMBA_CTRL_OFS) begin
            ctrl_q <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_q <= 32'h0000_0000;
        end else if (wb_take && !wb_we_i) begin
            case (wb_adr_i)
                `PMBA_CTRL_OFS: wb_dat_q <= {30'h0, ctrl_q};
                `PMBA_STAT_OFS: wb_dat_q <= {26'h0, state_q, stat_q};
                `PMBA_CNT_OFS: wb_dat_q <= {16'h0, xfer_cnt_q};
                default: wb_dat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign sys_data_o = sys_data_q;
    assign sys_data_oe_n_o = oe_n_q;
    assign sys_ack_o = sys_ack_q;
    assign buffered_address_o = ma_q;

    // Checks on the access path.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_take;
        take;
    endsequence

    sequence s_take_byte_read_up;
        take && xfer && byte_mode && !sys_we_i && upper_lane;
    endsequence

    chk_shift_route: assert property (
        shift |=> buffered_address_o == $past(~sys_addr_n_i[14:0]))
        else $error("shifted address routing wrong");

    chk_plain_route: assert property (
        !shift |=> buffered_address_o == $past(~sys_addr_n_i[15:1]))
        else $error("unshifted address routing wrong");

    chk_space_gate: assert property (
        s_take ##0 !space_ok |-> ##`PMBA_ANSWER_LAT (!sys_ack_o && &sys_data_oe_n_o))
        else $error("board answered outside its memory space");

    chk_board_half: assert property (
        s_take ##0 (space_ok && !board_ok) |=> !(arr.low_en || arr.high_en) [*2])
        else $error("array touched for the other board half");

    chk_inhibit_block: assert property (
        s_take ##0 !array_inhibit_n_i |=> !(arr.low_en || arr.high_en) [*2]
            ##1 &sys_data_oe_n_o)
        else $error("array transfer while inhibited");

    chk_byte_lanes: assert property (
        s_take ##0 (xfer && byte_mode) |=> (arr.low_en != arr.high_en)
            && (arr.high_en == $past(lbb)))
        else $error("byte mode selected wrong array");

    chk_word_both: assert property (
        s_take ##0 (xfer && word_mode) |=> arr.low_en && arr.high_en)
        else $error("word mode did not enable both arrays");

    chk_upper_lane: assert property (
        s_take_byte_read_up |-> ##`PMBA_ANSWER_LAT (sys_data_oe_n_o == 2'h1 && sys_ack_o))
        else $error("byte read not on upper lanes");

    chk_idle_quiet: assert property (
        state_q == PMBA_IDLE |-> &sys_data_oe_n_o && !arr.low_en && !arr.high_en)
        else $error("bus driven while idle");
endmodule

/* dv/pmba_emu_model.sv */
`timescale 1ns/100ps
// Emulator on the system bus; it holds a request until answered or gives up.
module pmba_emu_model (
    input wire logic clk_i,
    input wire logic sys_ack_i,
    input wire logic [15:0] sys_data_i,
    input wire logic [1:0] sys_oe_n_i,
    input wire logic [14:0] buf_addr_i,
    output logic [15:0] sys_addr_n_o,
    output logic word_access_n_o,
    output logic narrow_access_n_o,
    output logic space_o,
    output logic array_inhibit_n_o,
    output logic lane_exchange_n_o,
    output logic sys_req_o,
    output logic sys_we_o,
    output logic [15:0] sys_data_o
);
    // Idle bus at time zero.
    initial begin
        sys_addr_n_o = 16'hFFFF;
        word_access_n_o = 1'b0;
        narrow_access_n_o = 1'b0;
        space_o = 1'b1;
        array_inhibit_n_o = 1'b1;
        lane_exchange_n_o = 1'b1;
        sys_req_o = 1'b0;
        sys_we_o = 1'b0;
        sys_data_o = 16'hA5C3;
    end

    // Mode levels change only between requests.
    task automatic set_mode(input logic wd_n, input logic nar_n, input logic xn,
                            input logic spc, input logic inh_n);
        @(posedge clk_i);
        word_access_n_o <= wd_n;
        narrow_access_n_o <= nar_n;
        lane_exchange_n_o <= xn;
        space_o <= spc;
        array_inhibit_n_o <= inh_n;
    endtask

    // One transfer; an unqualified board never answers, so the wait is cut at 8 edges.
    task automatic access(input logic [15:0] a, input logic we, input logic [15:0] wd,
                          output logic [15:0] rd, output logic [1:0] oe, output logic ok,
                          output logic [14:0] ba);
        int n;
        @(posedge clk_i);
        sys_addr_n_o <= ~a;
        sys_we_o <= we;
        sys_data_o <= wd;
        sys_req_o <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 8 && ok !== 1'b1; n++) begin
            @(posedge clk_i);
            ok = sys_ack_i;
            rd = sys_data_i;
            oe = sys_oe_n_i;
            ba = buf_addr_i;
        end
        // Released lines flip so that a stale capture cannot pass.
        sys_req_o <= 1'b0;
        sys_addr_n_o <= a;
        sys_data_o <= ~wd;
        @(posedge clk_i);
    endtask
endmodule

/* dv/pmba_board_tb.sv */
`timescale 1ns/100ps
module pmba_board_tb
    import pmba_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, wd_n, nar_n, spc, inh_n, xn, req, swe, sack;
    logic [15:0] a_n, sd_i, sd_o;
    logic [1:0] oe_n;
    logic [14:0] ba, ba_q;
    int err_total = 0;
    int n_compared = 0;

    // Free running 125 MHz clock.
    always #4 clk = ~clk;

    pmba_board i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sys_addr_n_i(a_n), .word_access_n_i(wd_n),
        .narrow_access_n_i(nar_n), .memory_space_select_i(spc), .array_inhibit_n_i(inh_n),
        .lane_exchange_n_i(xn), .sys_req_i(req), .sys_we_i(swe), .sys_data_i(sd_i),
        .sys_data_o(sd_o), .sys_data_oe_n_o(oe_n), .sys_ack_o(sack),
        .buffered_address_o(ba));

    pmba_emu_model i_emu (.clk_i(clk), .sys_ack_i(sack), .sys_data_i(sd_o),
        .sys_oe_n_i(oe_n), .buf_addr_i(ba), .sys_addr_n_o(a_n), .word_access_n_o(wd_n),
        .narrow_access_n_o(nar_n), .space_o(spc), .array_inhibit_n_o(inh_n),
        .lane_exchange_n_o(xn), .sys_req_o(req), .sys_we_o(swe), .sys_data_o(sd_i));

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic single Wishbone cycle, held until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask

    // Only the lanes expected to be driven are compared.
    task automatic go(input logic [15:0] a, input logic w, input logic [15:0] wd,
                      input logic ok_x, input logic [1:0] oe_x, input logic [15:0] rd_x);
        logic [15:0] rd;
        logic [1:0] oe;
        logic ok;
        i_emu.access(a, w, wd, rd, oe, ok, ba_q);
        check("ack", {31'h0, ok}, {31'h0, ok_x});
        check("lanes", {30'h0, oe}, {30'h0, oe_x});
        check("rdata", {16'h0, rd & {{8{~oe_x[1]}}, {8{~oe_x[0]}}}}, {16'h0, rd_x});
        // A missing answer means the model's bounded wait ran out; a missing or unexpected answer stops here.
        if (ok !== ok_x) begin
            close_out();
        end
    endtask

    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, 8'h00, 32'h0, q);
        check("ctrl_rst", q, 32'h00000001);
        wb(1'b0, 8'h0C, 32'h0, q);
        check("unmapped", q, 32'h00000000);
        wb(1'b1, 8'h00, 32'h00000002, q);
        wb(1'b0, 8'h00, 32'h0, q);
        check("ctrl_rw", q, 32'h00000002);
        wb(1'b1, 8'h00, 32'h00000001, q);
    endtask

    task automatic t_word();
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        go(16'h0100, 1'b1, 16'hBEEF, 1'b1, 2'b11, 16'h0000);
        check("buf_addr", {17'h0, ba_q}, 32'h00000080);
        go(16'h0100, 1'b0, 16'h0000, 1'b1, 2'b00, 16'hBEEF);
    endtask

    // Byte lanes move up when the exchange control is low.
    task automatic t_byte(input logic x);
        logic [1:0] oe_e;
        oe_e = x ? 2'b10 : 2'b01;
        i_emu.set_mode(1'b1, 1'b0, x, 1'b1, 1'b1);
        go(16'h0200, 1'b1, x ? 16'hA55A : 16'h5AA5, 1'b1, 2'b11, 16'h0000);
        go(16'h0201, 1'b1, x ? 16'h3CC3 : 16'hC33C, 1'b1, 2'b11, 16'h0000);
        go(16'h0200, 1'b0, 16'h0000, 1'b1, oe_e, x ? 16'h005A : 16'h5A00);
        go(16'h0201, 1'b0, 16'h0000, 1'b1, oe_e, x ? 16'h00C3 : 16'hC300);
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        go(16'h0200, 1'b0, 16'h0000, 1'b1, 2'b00, 16'hC35A);
    endtask

    task automatic t_shift();
        i_emu.set_mode(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        go(16'h0300, 1'b1, 16'h1357, 1'b1, 2'b11, 16'h0000);
        check("buf_shift", {17'h0, ba_q}, 32'h00000300);
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        go(16'h0600, 1'b0, 16'h0000, 1'b1, 2'b00, 16'h1357);
    endtask

    task automatic t_space();
        logic [31:0] q;
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        go(16'h0100, 1'b0, 16'h0000, 1'b0, 2'b11, 16'h0000);
        wb(1'b1, 8'h00, 32'h00000000, q);
        go(16'h0100, 1'b0, 16'h0000, 1'b1, 2'b00, 16'hBEEF);
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        go(16'h0100, 1'b0, 16'h0000, 1'b0, 2'b11, 16'h0000);
        wb(1'b1, 8'h00, 32'h00000003, q);
        go(16'h8100, 1'b0, 16'h0000, 1'b1, 2'b00, 16'hBEEF);
        check("buf_high", {17'h0, ba_q}, 32'h00004080);
        go(16'h0100, 1'b0, 16'h0000, 1'b0, 2'b11, 16'h0000);
        wb(1'b1, 8'h00, 32'h00000001, q);
    endtask

    // Inhibited, unqualified and modeless writes must all leave the cell alone.
    task automatic t_inhibit();
        logic [31:0] q;
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        go(16'h0100, 1'b1, 16'h1234, 1'b1, 2'b11, 16'h0000);
        go(16'h0100, 1'b0, 16'h0000, 1'b1, 2'b11, 16'h0000);
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        go(16'h0100, 1'b1, 16'h9999, 1'b0, 2'b11, 16'h0000);
        i_emu.set_mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        go(16'h0100, 1'b1, 16'h7777, 1'b0, 2'b11, 16'h0000);
        i_emu.set_mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        go(16'h0100, 1'b0, 16'h0000, 1'b1, 2'b00, 16'hBEEF);
        // Seventeen qualified, uninhibited accesses were made since reset.
        wb(1'b0, 8'h08, 32'h0, q);
        check("xfer_count", q, 32'h00000011);
        // Last request was a plain word hit; the sequencer is idle again.
        wb(1'b0, 8'h04, 32'h0, q);
        check("status", q, 32'h00000003);
    endtask

    // Reset for 12 cycles, then every scenario in turn.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_word();
        t_byte(1'b1);
        t_byte(1'b0);
        t_shift();
        t_space();
        t_inhibit();
        close_out();
    end
endmodule
